/* File: hdl/pmcc_ctrl.sv */
// power mode and system clock controller with wishbone register slave
//
// Decided for this implementation: the register offsets and register access over Wishbone.
`timescale 1ns/1ps
module pmcc_ctrl #(
  parameter int high_settle = pmcc_pkg::high_settle_cycles
) (
  input wire logic clock_i,
  input wire logic srst_i,
  // wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // cpu side
  input wire logic halt_i,
  input wire logic wake_i,
  input wire logic clear_pdf_i,
  input wire logic timeout_set_i,
  output logic cpu_run_o,
  output logic power_down_flag_o,
  output logic timeout_flag_o,
  // clock gating controls
  output logic high_osc_en_o,
  output logic low_osc_en_o,
  output logic sys_clk_en_o,
  output logic sys_use_low_o,
  output logic [2:0] sys_div_sel_o,
  output logic periph_div_en_o,
  output logic sub_clk_en_o,
  output logic wdt_clear_o,
  output logic wdt_halt_o
);
  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  logic [2:0] clock_divider_select; // divided clock choice
  logic fast_wakeup_enable; // temporary low clock on wake
  logic idle_enable; // halt goes idle rather than sleep
  logic high_clock_select; // undivided high clock
  logic idle_clock_keep; // keep system clock in idle
  logic wdt_on; // watchdog enabled, from software
  logic lvd_on; // low voltage detect enabled
  logic [1:0] osc_choice; // system oscillator type
  logic high_osc_ready;
  logic low_osc_ready;
  logic [10:0] high_cnt; // high settle counter
  logic [1:0] low_cnt; // low settle counter
  pmcc_pkg::pmcc_mode_type mode;
  logic fast_active; // running on low clock after fast wake
  logic wb_hit;
  logic low_selected; // low clock picked as system clock
  logic in_halt;
  logic high_needed;
  logic low_needed;
  logic [10:0] high_target; // last count before the ready flag rises

  // divider code below 010 means low clock
  function automatic logic is_low_code(input logic [2:0] code);
    is_low_code = (code[2:1] == 2'b00);
  endfunction

  assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign low_selected = !high_clock_select &&
                        is_low_code(clock_divider_select);
  assign in_halt = (mode == pmcc_pkg::pmcc_deep_sleep) ||
                   (mode == pmcc_pkg::pmcc_sleep_sub) ||
                   (mode == pmcc_pkg::pmcc_idle_off) ||
                   (mode == pmcc_pkg::pmcc_idle_on);

  // ----------------------------------------------------------------
  // wishbone slave: one registered ack per request, one wait state
  // ----------------------------------------------------------------
  // ack answers one edge after the strobe and drops the next cycle
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_hit;
    end
  end

  // read data; unmapped offsets read zero, so no bus error is needed
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (wb_hit && !wb_we_i) begin
      unique case (wb_adr_i)
        pmcc_pkg::mode_ctrl_addr: begin
          wb_dat_o <= {24'h00_0000, clock_divider_select,
                       fast_wakeup_enable, low_osc_ready, high_osc_ready,
                       idle_enable, high_clock_select};
        end
        pmcc_pkg::aux_ctrl_addr: begin
          wb_dat_o <= {27'h000_0000, osc_choice, lvd_on, wdt_on,
                       idle_clock_keep};
        end
        pmcc_pkg::status_addr: begin
          wb_dat_o <= {26'h000_0000, fast_active, mode,
                       timeout_flag_o, power_down_flag_o};
        end
        default: begin
          wb_dat_o <= 32'h0000_0000;
        end
      endcase
    end
  end

  // software writes to control fields; ready flags are read-only
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      {clock_divider_select, fast_wakeup_enable} <=
        {pmcc_pkg::mode_ctrl_rst[7:5], pmcc_pkg::mode_ctrl_rst[4]};
      idle_enable <= pmcc_pkg::mode_ctrl_rst[pmcc_pkg::idle_en_bit];
      high_clock_select <= pmcc_pkg::mode_ctrl_rst[pmcc_pkg::hsel_bit];
      {osc_choice, lvd_on, wdt_on, idle_clock_keep} <=
        pmcc_pkg::aux_ctrl_rst[4:0];
    end else if (wb_hit && wb_we_i && wb_sel_i[0]) begin
      // normal/slow switching happens only through these writes
      if (wb_adr_i == pmcc_pkg::mode_ctrl_addr) begin
        clock_divider_select <= wb_dat_i[pmcc_pkg::div_lsb +: 3];
        fast_wakeup_enable <= wb_dat_i[pmcc_pkg::fast_bit];
        idle_enable <= wb_dat_i[pmcc_pkg::idle_en_bit];
        high_clock_select <= wb_dat_i[pmcc_pkg::hsel_bit];
      end else if (wb_adr_i == pmcc_pkg::aux_ctrl_addr) begin
        idle_clock_keep <= wb_dat_i[pmcc_pkg::keep_bit];
        wdt_on <= wb_dat_i[pmcc_pkg::wdt_on_bit];
        lvd_on <= wb_dat_i[pmcc_pkg::lvd_on_bit];
        osc_choice <= wb_dat_i[pmcc_pkg::osc_lsb +: 2];
      end
    end
  end

  // ----------------------------------------------------------------
  // operating mode sequencer
  // ----------------------------------------------------------------
  // halt picks the low-power mode; wake returns to the run mode
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      mode <= pmcc_pkg::pmcc_normal;
    end else begin
      unique case (mode)
        pmcc_pkg::pmcc_normal, pmcc_pkg::pmcc_slow: begin
          if (halt_i) begin
            if (!idle_enable && !wdt_on && !lvd_on) begin
              mode <= pmcc_pkg::pmcc_deep_sleep;
            end else if (!idle_enable) begin
              mode <= pmcc_pkg::pmcc_sleep_sub;
            end else if (!idle_clock_keep) begin
              mode <= pmcc_pkg::pmcc_idle_off;
            end else begin
              mode <= pmcc_pkg::pmcc_idle_on;
            end
          end else begin
            mode <= low_selected ? pmcc_pkg::pmcc_slow :
                                   pmcc_pkg::pmcc_normal;
          end
        end
        default: begin
          if (wake_i) begin
            mode <= low_selected ? pmcc_pkg::pmcc_slow :
                                   pmcc_pkg::pmcc_normal;
          end
        end
      endcase
    end
  end

  // fast wake: crystal, enable set, and a mode that kept the low clock
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      fast_active <= 1'b0;
    end else if (in_halt && wake_i) begin
      fast_active <= fast_wakeup_enable && !low_selected &&
        (osc_choice == pmcc_pkg::pmcc_osc_crystal) &&
        ((mode == pmcc_pkg::pmcc_sleep_sub) ||
         (mode == pmcc_pkg::pmcc_idle_off));
    end else if (high_osc_ready) begin
      fast_active <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // oscillator enables and settle counters
  // ----------------------------------------------------------------
  // high oscillator off when low clock chosen or in stopped modes
  assign high_needed = !low_selected &&
    ((mode == pmcc_pkg::pmcc_normal) || (mode == pmcc_pkg::pmcc_slow) ||
     (mode == pmcc_pkg::pmcc_idle_on));
  // low clock stops in deep sleep, runs while it is in use
  assign low_needed = (mode != pmcc_pkg::pmcc_deep_sleep) &&
    (low_selected || fast_active || wdt_on || lvd_on ||
     (mode == pmcc_pkg::pmcc_sleep_sub) ||
     (mode == pmcc_pkg::pmcc_idle_off));

  // a slow internal system oscillator settles as fast as the low clock,
  // so it must not sit out the long crystal count
  assign high_target = (osc_choice == pmcc_pkg::pmcc_osc_slow_int) ?
    11'(pmcc_pkg::low_settle_cycles - 1) : 11'(high_settle - 1);

  // high counter restarts whenever the oscillator is disabled
  always_ff @(posedge clock_i) begin
    if (srst_i || !high_needed) begin
      high_cnt <= 11'h000;
      high_osc_ready <= 1'b0;
    end else if (high_cnt >= high_target) begin
      high_osc_ready <= 1'b1;
    end else begin
      high_cnt <= high_cnt + 11'h001;
    end
  end

  // low counter gives the two cycle slow oscillator start
  always_ff @(posedge clock_i) begin
    if (srst_i || !low_needed) begin
      low_cnt <= 2'h0;
      low_osc_ready <= 1'b0;
    end else if (low_cnt ==
                 2'(pmcc_pkg::low_settle_cycles - 1)) begin
      low_osc_ready <= 1'b1;
    end else begin
      low_cnt <= low_cnt + 2'h1;
    end
  end

  // ----------------------------------------------------------------
  // clock outputs
  // ----------------------------------------------------------------
  assign high_osc_en_o = high_needed;
  assign low_osc_en_o = low_needed;
  // system clock runs in run modes and idle_on once its source settles
  assign sys_clk_en_o = ((mode == pmcc_pkg::pmcc_normal) ||
                         (mode == pmcc_pkg::pmcc_slow) ||
                         (mode == pmcc_pkg::pmcc_idle_on)) &&
    (low_selected || fast_active ? low_osc_ready
                                 : high_osc_ready);
  assign sys_use_low_o = low_selected || fast_active;
  assign sys_div_sel_o = high_clock_select ? 3'h0 :
                         clock_divider_select;
  assign periph_div_en_o = high_needed && high_osc_ready;
  assign sub_clk_en_o = (mode != pmcc_pkg::pmcc_deep_sleep);
  assign cpu_run_o = !in_halt && sys_clk_en_o;
  assign wdt_halt_o = (mode == pmcc_pkg::pmcc_deep_sleep);

  // watchdog clear pulse on every halt entry
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      wdt_clear_o <= 1'b0;
    end else begin
      wdt_clear_o <= halt_i && !in_halt;
    end
  end

  // power down flag: halt sets, clear instruction clears, set wins
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      power_down_flag_o <= 1'b0;
    end else if (halt_i && !in_halt) begin
      power_down_flag_o <= 1'b1;
    end else if (clear_pdf_i) begin
      power_down_flag_o <= 1'b0;
    end
  end

  // timeout flag: watchdog time-out sets, halt clears, set wins
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      timeout_flag_o <= 1'b0;
    end else if (timeout_set_i) begin
      timeout_flag_o <= 1'b1;
    end else if (halt_i && !in_halt) begin
      timeout_flag_o <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence halt_taken;
    halt_i && !in_halt;
  endsequence

  // the high oscillator has settled while the low clock still drives
  sequence fast_done;
    fast_active && high_osc_ready && !in_halt;
  endsequence

  chk_high_select_div: assert property (@(posedge clock_i)
    disable iff (srst_i) high_clock_select |-> sys_div_sel_o == 3'h0)
    else $error("high select must give undivided clock");
  chk_low_stops_high: assert property (@(posedge clock_i)
    disable iff (srst_i) low_selected |-> !high_osc_en_o)
    else $error("high oscillator left on with low clock");
  chk_deep_no_fast: assert property (@(posedge clock_i)
    disable iff (srst_i) (mode == pmcc_pkg::pmcc_deep_sleep && wake_i)
    |=> !fast_active)
    else $error("fast wake used after deep sleep");
  chk_deep_entry: assert property (@(posedge clock_i)
    disable iff (srst_i) halt_taken ##0 (!idle_enable && !wdt_on
    && !lvd_on) |=> wdt_halt_o && !sys_clk_en_o && wdt_clear_o)
    else $error("deep sleep entry wrong");
  chk_idle_on_runs: assert property (@(posedge clock_i)
    disable iff (srst_i) (mode == pmcc_pkg::pmcc_idle_on) |->
    sub_clk_en_o && !cpu_run_o)
    else $error("idle_on wrong clocks");
  chk_halt_flags: assert property (@(posedge clock_i)
    disable iff (srst_i) halt_taken ##0 !timeout_set_i |=>
    power_down_flag_o && !timeout_flag_o)
    else $error("halt flags not updated");
  chk_low_ready_time: assert property (@(posedge clock_i)
    disable iff (srst_i) $rose(low_needed) |-> ##[1:2] low_osc_ready)
    else $error("low ready late");
  chk_high_ready_time: assert property (@(posedge clock_i)
    disable iff (srst_i) $rose(high_needed) &&
    (osc_choice != pmcc_pkg::pmcc_osc_slow_int) |-> !high_osc_ready [*8])
    else $error("high ready too early");
  chk_periph_stop: assert property (@(posedge clock_i)
    disable iff (srst_i) low_selected |-> !periph_div_en_o)
    else $error("divided clocks run on low clock");
  chk_fast_release: assert property (@(posedge clock_i)
    disable iff (srst_i) fast_done |=> !fast_active)
    else $error("fast wake kept the low clock too long");
  chk_idle_on_clock: assert property (@(posedge clock_i)
    disable iff (srst_i) halt_taken ##0 (idle_enable && idle_clock_keep
    && sys_clk_en_o) |=> sys_clk_en_o && sub_clk_en_o)
    else $error("idle_on stopped the system clock");
  chk_slow_int_wake: assert property (@(posedge clock_i)
    disable iff (srst_i) (in_halt && wake_i &&
    osc_choice == pmcc_pkg::pmcc_osc_slow_int) |-> ##[1:3] cpu_run_o)
    else $error("slow oscillator wake too long");
endmodule

/* File: hdl/pmcc_pkg.sv */
// package: register map, field layout and timing constants of the clock controller
package pmcc_pkg;
  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [3:0] mode_ctrl_addr = 4'h0; // system_mode_control
  localparam logic [3:0] aux_ctrl_addr = 4'h4;  // idle_clock_keep etc
  localparam logic [3:0] status_addr = 4'h8;    // flags and mode
  // ----------------------------------------------------------------
  // field positions of system_mode_control
  // ----------------------------------------------------------------
  localparam int hsel_bit = 0;
  localparam int idle_en_bit = 1;
  localparam int hready_bit = 2;
  localparam int lready_bit = 3;
  localparam int fast_bit = 4;
  localparam int div_lsb = 5;
  // field positions of aux control
  localparam int keep_bit = 0;
  localparam int wdt_on_bit = 1;
  localparam int lvd_on_bit = 2;
  localparam int osc_lsb = 3;
  // ----------------------------------------------------------------
  // values after reset
  // ----------------------------------------------------------------
  localparam logic [7:0] mode_ctrl_rst = 8'h03;
  localparam logic [7:0] aux_ctrl_rst = 8'h00;
  // ----------------------------------------------------------------
  // stabilisation counts
  // ----------------------------------------------------------------
  localparam int high_settle_cycles = 1024;
  localparam int low_settle_cycles = 2;
  localparam int div_width = 6;
  // system oscillator choice
  typedef enum logic [1:0] {
    pmcc_osc_crystal,
    pmcc_osc_fast_int,
    pmcc_osc_slow_int,
    pmcc_osc_rsvd
  } pmcc_osc_type;
  // operating modes
  typedef enum logic [2:0] {
    pmcc_normal,
    pmcc_slow,
    pmcc_deep_sleep,
    pmcc_sleep_sub,
    pmcc_idle_off,
    pmcc_idle_on
  } pmcc_mode_type;
endpackage

/* File: test/pmcc_ctrl_tb_top.sv */
// self-checking bench for the power mode and clock controller
`timescale 1ns/1ps
module pmcc_ctrl_tb_top;
  // ---------------------------------------------------------------
  // signals and counters
  // ---------------------------------------------------------------
  localparam int settle = 8; // shortened settle count keeps runs short
  logic clock_i, srst_i, wb_cyc_i, wb_stb_i, wb_we_i;
  logic [3:0] wb_adr_i, wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic wb_ack_o, halt_i, wake_i, clear_pdf_i, timeout_set_i, cpu_run_o;
  logic power_down_flag_o, timeout_flag_o, high_osc_en_o, low_osc_en_o;
  logic sys_clk_en_o, sys_use_low_o, periph_div_en_o, sub_clk_en_o;
  logic wdt_clear_o, wdt_halt_o;
  logic [2:0] sys_div_sel_o;
  int checks = 0; // comparisons made
  int fail_count = 0; // mismatches seen
  int cyc_count = 0; // watchdog on the bench itself
  int clr_seen = 0; // watchdog clear pulses seen
  pmcc_ctrl #(.high_settle(settle)) pmcc_ctrl_i (.clock_i(clock_i),
    .srst_i(srst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .halt_i(halt_i), .wake_i(wake_i), .clear_pdf_i(clear_pdf_i),
    .timeout_set_i(timeout_set_i), .cpu_run_o(cpu_run_o),
    .power_down_flag_o(power_down_flag_o),
    .timeout_flag_o(timeout_flag_o), .high_osc_en_o(high_osc_en_o),
    .low_osc_en_o(low_osc_en_o), .sys_clk_en_o(sys_clk_en_o),
    .sys_use_low_o(sys_use_low_o), .sys_div_sel_o(sys_div_sel_o),
    .periph_div_en_o(periph_div_en_o), .sub_clk_en_o(sub_clk_en_o),
    .wdt_clear_o(wdt_clear_o), .wdt_halt_o(wdt_halt_o));
  // ---------------------------------------------------------------
  // clock and hang guard
  // ---------------------------------------------------------------
  initial begin
    clock_i = 1'b0;
    forever #12.5 clock_i = ~clock_i;
  end
  // a stuck handshake would otherwise spin forever
  always @(posedge clock_i) begin
    cyc_count++;
    if (wdt_clear_o === 1'b1) clr_seen++;
    if (cyc_count == 20000) begin
      fail_count++;
      stop_test();
    end
  end
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one classic cycle: held until ack is sampled high
  task automatic wb(input logic [3:0] a, input logic we,
                    input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clock_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_sel_i <= 4'h1;
    wb_adr_i <= a;
    wb_dat_i <= wd;
    do @(posedge clock_i); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask
  function automatic logic [31:0] mc(input logic [2:0] dv,
      input logic fs, input logic idl, input logic hs);
    return (32'(dv) << pmcc_pkg::div_lsb) | (32'(fs) << pmcc_pkg::fast_bit)
      | (32'(idl) << pmcc_pkg::idle_en_bit) | 32'(hs);
  endfunction
  function automatic logic [31:0] ax(input logic [1:0] osc,
      input logic low_voltage_detect, input logic wdt, input logic keep);
    return (32'(osc) << pmcc_pkg::osc_lsb) | (32'(low_voltage_detect) << 2)
      | (32'(wdt) << 1) | 32'(keep);
  endfunction
  // halt mode expected from the idle, keep and watchdog/lvd settings
  function automatic logic [2:0] exp_mode(input logic idl,
      input logic keep, input logic on);
    if (!idl) return on ? 3'(pmcc_pkg::pmcc_sleep_sub) :
      3'(pmcc_pkg::pmcc_deep_sleep);
    return keep ? 3'(pmcc_pkg::pmcc_idle_on) : 3'(pmcc_pkg::pmcc_idle_off);
  endfunction
  // one-cycle pulse on a cpu-side strobe: 0 halt, 1 timeout, 2 clear
  task automatic pulse(input int which);
    @(posedge clock_i);
    case (which)
      0: halt_i <= 1'b1;
      1: timeout_set_i <= 1'b1;
      default: clear_pdf_i <= 1'b1;
    endcase
    @(posedge clock_i);
    {halt_i, timeout_set_i, clear_pdf_i} <= 3'h0;
    repeat (3) @(posedge clock_i);
  endtask
  // wake request, returns edges until the cpu may run again
  task automatic wake(output int n);
    @(posedge clock_i);
    wake_i <= 1'b1;
    @(posedge clock_i);
    wake_i <= 1'b0;
    n = 0;
    while (cpu_run_o !== 1'b1) begin
      @(posedge clock_i);
      n++;
    end
  endtask
  // fast wake case: halt, wake, time the return
  task automatic fw(input logic [1:0] osc, input logic fs,
      input logic wdt, input logic idl, input logic quick);
    logic [31:0] d;
    int n;
    wb(pmcc_pkg::aux_ctrl_addr, 1'b1, ax(osc, 1'b0, wdt, 1'b0), d);
    wb(pmcc_pkg::mode_ctrl_addr, 1'b1, mc(3'h0, fs, idl, 1'b1), d);
    repeat (settle + 4) @(posedge clock_i);
    pulse(0);
    wake(n);
    if (quick) chk("short wake", 1, 32'(n <= 3));
    else chk("long wake", 1, 32'(n >= settle - 2 && n <= settle + 3));
    if (quick && osc == 2'h0) begin
      chk("low clock first", 1, 32'(sys_use_low_o));
      n = 0;
      while (sys_use_low_o !== 1'b0) begin
        @(posedge clock_i);
        n++;
      end
      chk("switch back", 1, 32'(n >= settle - 4 && n <= settle + 3));
      wb(pmcc_pkg::mode_ctrl_addr, 1'b0, 32'h0000_0000, d);
      chk("high ready", 1, 32'(d[pmcc_pkg::hready_bit]));
    end
    $display("test fast wake osc %0d done", osc);
  endtask
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    logic [31:0] d;
    logic [2:0] c;
    logic [2:0] m;
    int n;
    {srst_i, wb_cyc_i, wb_stb_i, wb_we_i, halt_i, wake_i} = 6'h20;
    {clear_pdf_i, timeout_set_i, wb_adr_i, wb_dat_i} = '0;
    wb_sel_i = 4'h1;
    n = $urandom(32'h7b8f);
    repeat (5) @(posedge clock_i);
    srst_i <= 1'b0;
    wb(pmcc_pkg::mode_ctrl_addr, 1'b0, 32'h0000_0000, d);
    chk("reset select", 32'h0000_0003, d & 32'h0000_0003);
    repeat (settle + 4) @(posedge clock_i);
    wb(pmcc_pkg::mode_ctrl_addr, 1'b0, 32'h0000_0000, d);
    chk("settled high", 1, 32'(d[pmcc_pkg::hready_bit]));
    wb(4'hc, 1'b0, 32'h0000_0000, d);
    chk("unmapped read", 32'h0000_0000, d);
    $display("test reset done");
    // every divider code, then random ones
    for (int i = 0; i < 14; i++) begin
      c = (i < 8) ? 3'(i) : 3'($urandom_range(7, 0));
      wb(pmcc_pkg::mode_ctrl_addr, 1'b1, mc(c, 1'b0, 1'b1, 1'b0), d);
      repeat (3) @(posedge clock_i);
      chk("use low", 32'(c < 2), 32'(sys_use_low_o));
      chk("high osc", 32'(c >= 2), 32'(high_osc_en_o));
      chk("periph div", 32'(c >= 2), 32'(periph_div_en_o));
      if (c >= 2) chk("div code", 32'(c), 32'(sys_div_sel_o));
      wb(pmcc_pkg::mode_ctrl_addr, 1'b0, 32'h0000_0000, d);
      if (c < 2) chk("low ready", 1, 32'(d[pmcc_pkg::lready_bit]));
      wb(pmcc_pkg::mode_ctrl_addr, 1'b1, mc(c, 1'b0, 1'b1, 1'b1), d);
      repeat (2) @(posedge clock_i);
      chk("undivided", 32'h0000_0000, 32'(sys_div_sel_o));
      chk("high source", 0, 32'(sys_use_low_o));
      repeat (settle + 4) @(posedge clock_i);
    end
    $display("test divider done");
    // all halt mode combinations
    for (int i = 0; i < 16; i++) begin
      wb(pmcc_pkg::aux_ctrl_addr, 1'b1, ax(2'h0, i[2], i[1], i[0]), d);
      wb(pmcc_pkg::mode_ctrl_addr, 1'b1, mc(3'h0, 1'b0, i[3], 1'b1), d);
      m = exp_mode(i[3], i[0], i[1] | i[2]);
      pulse(1);
      n = clr_seen;
      pulse(0);
      chk("wdt clear", 32'(n + 1), 32'(clr_seen));
      wb(pmcc_pkg::status_addr, 1'b0, 32'h0000_0000, d);
      chk("mode", 32'(m), 32'(d[4:2]));
      chk("flags", 32'h0000_0001, d & 32'h0000_0003);
      chk("cpu stop", 0, 32'(cpu_run_o));
      chk("sys clk", 32'(m == 3'(pmcc_pkg::pmcc_idle_on)),
          32'(sys_clk_en_o));
      chk("sub clk", 32'(m != 3'(pmcc_pkg::pmcc_deep_sleep)),
          32'(sub_clk_en_o));
      chk("wdt halt", 32'(m == 3'(pmcc_pkg::pmcc_deep_sleep)),
          32'(wdt_halt_o));
      if (m == 3'(pmcc_pkg::pmcc_deep_sleep)) begin
        chk("low stop", 0, 32'(low_osc_en_o));
        wb(pmcc_pkg::mode_ctrl_addr, 1'b0, 32'h0000_0000, d);
        chk("low ready sleep", 0, 32'(d[pmcc_pkg::lready_bit]));
      end
      wake(n);
      if (m == 3'(pmcc_pkg::pmcc_idle_on)) chk("quick wake", 1, 32'(n <= 3));
      else chk("slow wake", 1, 32'(n >= settle - 2 && n <= settle + 3));
      pulse(2);
      chk("pdf clear", 0, 32'(power_down_flag_o));
    end
    $display("test halt modes done");
    fw(2'h0, 1'b1, 1'b1, 1'b0, 1'b1);
    fw(2'h0, 1'b1, 1'b0, 1'b0, 1'b0);
    fw(2'h1, 1'b1, 1'b0, 1'b1, 1'b0);
    fw(2'h2, 1'b0, 1'b0, 1'b0, 1'b1);
    stop_test();
  end
endmodule
